// *** verilog/amx_defines.svh ***
`ifndef AMX_DEFINES_SVH
`define AMX_DEFINES_SVH

// clock period of clk_i
`define AMX_CLK_NS 25
// settle time allowed for ladder and comparator per trial bit
`define AMX_BIT_SETTLE_NS 200
// least time rounds up to whole cycles
`define AMX_BIT_CYC ((`AMX_BIT_SETTLE_NS + `AMX_CLK_NS - 1) / `AMX_CLK_NS)
`define AMX_RES_BITS 8
`define AMX_SEL_BITS 3
`define AMX_CHANNELS 8
`define AMX_CNT_BITS 4
`define AMX_DATA_RST 8'h00
`define AMX_SEL_RST 3'h0
`define AMX_SAR_MSB 8'h80

`endif

// *** verilog/amx_pkg.sv ***
package amx_pkg;
    typedef enum logic [4:0] {
        AMX_IDLE    = 5'h01,
        AMX_CLEAR   = 5'h02,
        AMX_CONVERT = 5'h04,
        AMX_LOAD    = 5'h08,
        AMX_FLAG    = 5'h10
    } amx_state_t;
    typedef logic [7:0] amx_code_t;
    typedef logic [2:0] amx_sel_t;
endpackage : amx_pkg

// *** verilog/amx_sync.sv ***
`timescale 1ns/10ps
module amx_sync #(
    parameter int W = 1
) (
    input wire logic clk_i, // system clock
    input wire logic sys_rst_i, // async reset, active high
    input wire logic [W-1:0] async_i, // pin levels
    output logic [W-1:0] sync_o // levels after two flops
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // first stage feeds the second stage only
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule : amx_sync

// *** verilog/amx_control.sv ***
`timescale 1ns/10ps
`include "amx_defines.svh"
module amx_control (
    input wire logic clk_i, // 40 MHz conversion clock
    input wire logic sys_rst_i, // async reset, active high
    input wire logic conversion_trigger_i, // start pulse pin
    input wire logic addr_strobe_i, // address latch strobe pin
    input wire amx_pkg::amx_sel_t chan_sel_i, // channel select pins, bit 2 is msb
    input wire logic out_en_i, // output enable pin, active high
    input wire logic cmp_i, // comparator: 1 when input >= trial level
    output amx_pkg::amx_code_t trial_code_o, // trial code to ladder tap
    output logic [`AMX_CHANNELS-1:0] analog_input_sel_o, // one-hot mux switch
    output amx_pkg::amx_code_t data_o, // result data lines
    output logic [`AMX_RES_BITS-1:0] data_oe_n_o, // low while driving data
    output logic eoc_o // end of conversion flag
);
    import amx_pkg::*;

    logic trig_s;
    logic ale_s;
    logic oe_s;
    logic cmp_s;
    amx_sel_t sel_s;
    logic trig_d_reg;
    logic ale_d_reg;

    // every pin, the comparator too, crosses two flops before use;
    // the cost is about three clocks of latency on each strobe,
    // which the eight-clock trial window and the flag bound absorb
    amx_sync #(.W(7)) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i({conversion_trigger_i, addr_strobe_i, out_en_i, cmp_i, chan_sel_i}),
        .sync_o({trig_s, ale_s, oe_s, cmp_s, sel_s})
    );

    wire trig_rise = trig_s & ~trig_d_reg;
    wire trig_fall = ~trig_s & trig_d_reg;
    wire ale_rise = ale_s & ~ale_d_reg;

    amx_state_t state_reg, state_next;
    amx_code_t sar_reg, sar_next;
    amx_code_t data_reg, data_next;
    amx_sel_t chan_reg, chan_next;
    logic [2:0] bit_reg, bit_next;
    logic [`AMX_CNT_BITS-1:0] cnt_reg, cnt_next;
    logic eoc_reg, eoc_next;

    always_comb begin
        state_next = state_reg;
        sar_next = sar_reg;
        data_next = data_reg;
        bit_next = bit_reg;
        cnt_next = cnt_reg;
        eoc_next = eoc_reg;
        case (state_reg)
            AMX_IDLE: begin
                state_next = AMX_IDLE;
            end
            AMX_CLEAR: begin
                sar_next = `AMX_DATA_RST;
                eoc_next = 1'b0;
                if (trig_fall) begin
                    state_next = AMX_CONVERT;
                    sar_next = `AMX_SAR_MSB;
                    bit_next = 3'(`AMX_RES_BITS - 1);
                    cnt_next = `AMX_CNT_BITS'(`AMX_BIT_CYC - 1);
                end
            end
            AMX_CONVERT: begin
                if (cnt_reg != '0) begin
                    cnt_next = cnt_reg - 1'b1;
                end else begin
                    // keep the bit only when input is at or above the trial level
                    if (!cmp_s) begin
                        sar_next[bit_reg] = 1'b0;
                    end
                    if (bit_reg == 3'h0) begin
                        state_next = AMX_LOAD;
                    end else begin
                        bit_next = bit_reg - 1'b1;
                        sar_next[bit_reg - 1'b1] = 1'b1;
                        cnt_next = `AMX_CNT_BITS'(`AMX_BIT_CYC - 1);
                    end
                end
            end
            AMX_LOAD: begin
                data_next = sar_reg;
                state_next = AMX_FLAG;
            end
            AMX_FLAG: begin
                eoc_next = 1'b1;
                state_next = AMX_IDLE;
            end
            default: begin
                state_next = AMX_IDLE;
            end
        endcase
        // a fresh rising edge wins from any state, aborting work in flight
        if (trig_rise) begin
            state_next = AMX_CLEAR;
            sar_next = `AMX_DATA_RST;
            eoc_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= AMX_IDLE;
            sar_reg <= `AMX_DATA_RST;
            data_reg <= `AMX_DATA_RST;
            bit_reg <= 3'h0;
            cnt_reg <= '0;
            eoc_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sar_reg <= sar_next;
            data_reg <= data_next;
            bit_reg <= bit_next;
            cnt_reg <= cnt_next;
            eoc_reg <= eoc_next;
        end
    end

    // edge detector group
    logic trig_d_next;
    logic ale_d_next;

    // delayed copies reset low, the idle level of both pins,
    // so release of reset never fakes a strobe or trigger edge
    always_comb begin
        trig_d_next = trig_s;
        ale_d_next = ale_s;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            trig_d_reg <= 1'b0;
            ale_d_reg <= 1'b0;
        end else begin
            trig_d_reg <= trig_d_next;
            ale_d_reg <= ale_d_next;
        end
    end

    // channel latch group: only a strobe edge may move the mux,
    // so a host may change the select pins freely between strobes
    always_comb begin
        chan_next = chan_reg;
        if (ale_rise) begin
            chan_next = sel_s;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            chan_reg <= `AMX_SEL_RST;
        end else begin
            chan_reg <= chan_next;
        end
    end

    // plain binary code to one switch; code 0 closes input 0
    function automatic logic [`AMX_CHANNELS-1:0] amx_onehot(input amx_sel_t code);
        logic [`AMX_CHANNELS-1:0] hot;
        hot = '0;
        hot[code] = 1'b1;
        return hot;
    endfunction : amx_onehot

    assign trial_code_o = sar_reg;
    assign analog_input_sel_o = amx_onehot(chan_reg);
    assign data_o = data_reg;

    // one enable per data line, all from the same synchronised pin,
    // so the lines never drive while the others float
    genvar gi;
    generate
        for (gi = 0; gi < `AMX_RES_BITS; gi = gi + 1) begin : g_oe
            assign data_oe_n_o[gi] = ~oe_s;
        end
    endgenerate
    assign eoc_o = eoc_reg;
endmodule : amx_control

// *** testbench/amx_far.sv ***
`timescale 1ns/10ps
module amx_far (
    input wire amx_pkg::amx_code_t trial_i, // ladder tap
    input wire logic [7:0] sel_i, // mux
    output logic cmp_o // comparator
);
    import amx_pkg::*;
    amx_code_t lvl;
    always_comb begin
        lvl = 8'h00;
        for (int k = 0; k < 8; k++) if (sel_i[k]) lvl = 8'(k * 36 + 3);
        cmp_o = lvl >= trial_i;
    end
endmodule : amx_far

// *** testbench/amx_asserts.sv ***
`timescale 1ns/10ps
module amx_asserts (
    input wire logic clk_i, // clk
    input wire logic sys_rst_i, // rst
    input wire logic conversion_trigger_i, // in
    input wire logic addr_strobe_i, // in
    input wire amx_pkg::amx_sel_t chan_sel_i, // in
    input wire logic out_en_i, // in
    input wire logic cmp_i, // in
    input wire amx_pkg::amx_code_t trial_code_o, // out
    input wire logic [7:0] analog_input_sel_o, // out
    input wire amx_pkg::amx_code_t data_o, // out
    input wire logic [7:0] data_oe_n_o, // out
    input wire logic eoc_o // out
);
    import amx_pkg::*;
    logic [7:0] cnt_reg;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // trial code 80 appears at the start of a run, and at its end only when the result is 80
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) cnt_reg <= 8'h00;
        else if (trial_code_o == 8'h80 && $past(trial_code_o) != 8'h80) cnt_reg <= 8'h01;
        else if (cnt_reg != 8'hFF) cnt_reg <= cnt_reg + 8'h01;
    end
    a_eoc_drop: assert property ($rose(conversion_trigger_i) |-> ##[1:8] !eoc_o)
        else $error("flag not low after trigger");
    a_trial_clear: assert property ($rose(conversion_trigger_i) |-> ##[1:5] trial_code_o == 8'h00)
        else $error("trial not cleared");
    a_data_first: assert property ($changed(data_o) |=> $rose(eoc_o))
        else $error("flag not after data");
    a_quiet_conv: assert property ($changed(trial_code_o) |-> !eoc_o)
        else $error("flag high while converting");
    a_trial_count: assert property ($rose(eoc_o) |-> cnt_reg inside {[8'h40:8'h44]})
        else $error("wrong conversion length");
    a_oe_on: assert property (out_en_i [*4] |-> data_oe_n_o == 8'h00)
        else $error("lines not driven");
    a_oe_off: assert property (!out_en_i [*4] |-> data_oe_n_o == 8'hFF)
        else $error("lines not released");
    a_sel_hold: assert property (!addr_strobe_i [*6] |-> $stable(analog_input_sel_o))
        else $error("mux moved without strobe");
    cover property ($rose(eoc_o));
    cover property ($fell(data_oe_n_o[0]));
    cover property ($rose(addr_strobe_i));
endmodule : amx_asserts
bind amx_control amx_asserts u_chk (.*);

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
    import amx_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, trig = 0, stb = 0, oe = 0, cmp, eoc;
    amx_sel_t sel = 3'h0;
    amx_code_t trial, data;
    logic [7:0] msel, oe_n;
    int fail_count = 0, checked = 0, cyc = 0;
    logic loop_on = 0;
    always @(posedge clk_i) if (loop_on) trig <= eoc;
    always #12.5 clk_i = ~clk_i;
    amx_control uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .conversion_trigger_i(trig),
        .addr_strobe_i(stb), .chan_sel_i(sel), .out_en_i(oe), .cmp_i(cmp),
        .trial_code_o(trial), .analog_input_sel_o(msel), .data_o(data),
        .data_oe_n_o(oe_n), .eoc_o(eoc));
    amx_far far (.trial_i(trial), .sel_i(msel), .cmp_o(cmp));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    task automatic convert(input amx_sel_t c);
        int i;
        tick(1);
        sel <= c;
        stb <= 1'b1;
        tick(3);
        stb <= 1'b0;
        tick(3);
        trig <= 1'b1;
        tick(3);
        trig <= 1'b0;
        tick(2);
        for (i = 0; i < 200 && eoc !== 1'b1; i++) tick(1);
        #1;
        `CHK("sel", 8'h01 << c, msel)
        `CHK("data", 8'(c * 36 + 3), data)
        `CHK("long", 1'b1, i > 60)
    endtask : convert
    task automatic t_sweep();
        for (int c = 0; c < 8; c++) convert(3'(c));
    endtask : t_sweep
    task automatic t_abort();
        tick(1);
        trig <= 1'b1;
        tick(3);
        trig <= 1'b0;
        tick(30);
        #1;
        `CHK("busy", 1'b0, eoc)
        convert(3'h6);
    endtask : t_abort
    task automatic t_oe();
        tick(1);
        sel <= 3'h1;
        oe <= 1'b1;
        tick(4);
        #1;
        `CHK("oe_on", 8'h00, oe_n)
        `CHK("held", 8'h40, msel)
        tick(1);
        oe <= 1'b0;
        tick(4);
        #1;
        `CHK("oe_off", 8'hFF, oe_n)
    endtask : t_oe
    task automatic t_loop();
        int n;
        int i;
        logic prev;
        n = 0;
        prev = eoc;
        tick(1);
        loop_on <= 1'b1;
        for (i = 0; i < 240; i++) begin
            tick(1);
            #1;
            if (eoc === 1'b1 && prev !== 1'b1) n++;
            prev = eoc;
        end
        tick(1);
        loop_on <= 1'b0;
        tick(1);
        trig <= 1'b0;
        tick(2);
        for (i = 0; i < 200 && eoc !== 1'b1; i++) tick(1);
        #1;
        `CHK("loops", 1'b1, n >= 2)
        `CHK("loop_data", 8'hDB, data)
    endtask : t_loop
    task automatic tally_and_finish();
        $display("checked %0d failed %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        tick(12);
        sys_rst_i <= 1'b0;
        tick(2);
        t_sweep();
        $display("sweep done");
        t_abort();
        $display("abort done");
        t_oe();
        $display("enable done");
        t_loop();
        $display("loop done");
        tally_and_finish();
    end
endmodule : testbench
